// [verilog/srb_pkg.sv]
`default_nettype none
package srb_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int         FRAME_BITS     = 16;
  localparam int         ACCESS_BIT     = 7;
  localparam int         ADR_MSB        = 6;
  localparam int         DATA_LSB       = 8;
  localparam logic [4:0] FRAME_LEN      = 5'h10;
  localparam logic [4:0] CNT_MAX        = 5'h11;
  localparam logic [4:0] CNT_ADDR_LAST  = 5'h06;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [1:0] REGION_CTRL    = 2'h0;
  localparam logic [1:0] REGION_STAT    = 2'h2;
  localparam logic [6:0] ADR_FAMILY_ID  = 7'h7e;
  // ----------------------------------------------------------------
  // control register indices (address bits 4:0, region 00)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_MODE_SUPPLY = 5'h01;
  localparam logic [4:0] IDX_HW_CTRL0    = 5'h02;
  localparam logic [4:0] IDX_WATCHDOG    = 5'h03;
  localparam logic [4:0] IDX_BUS_XCVR    = 5'h04;
  localparam logic [4:0] IDX_WAKE_INT    = 5'h06;
  localparam logic [4:0] IDX_WAKE_EXT    = 5'h07;
  localparam logic [4:0] IDX_WAKE_PULL   = 5'h08;
  localparam logic [4:0] IDX_BUS_FLASH   = 5'h0b;
  localparam logic [4:0] IDX_CYC_TIMER   = 5'h0c;
  localparam logic [4:0] IDX_HW_CTRL1    = 5'h0e;
  localparam logic [4:0] IDX_HW_CTRL2    = 5'h0f;
  localparam logic [4:0] IDX_IO_PIN      = 5'h17;
  localparam logic [4:0] IDX_PULSE_DUTY  = 5'h18;
  localparam logic [4:0] IDX_PULSE_FREQ  = 5'h1c;
  localparam logic [4:0] IDX_HW_CTRL3    = 5'h1d;
  localparam logic [4:0] IDX_SCRATCH_LO  = 5'h1e;
  localparam logic [4:0] IDX_SCRATCH_HI  = 5'h1f;
  // ----------------------------------------------------------------
  // status register indices (address bits 4:0, region 10)
  // ----------------------------------------------------------------
  localparam logic [4:0] SIDX_SUPPLY1  = 5'h00;
  localparam logic [4:0] SIDX_SUPPLY0  = 5'h01;
  localparam logic [4:0] SIDX_THERMAL  = 5'h02;
  localparam logic [4:0] SIDX_DEVICE   = 5'h03;
  localparam logic [4:0] SIDX_BUS_FAIL = 5'h04;
  localparam logic [4:0] SIDX_WAKE0    = 5'h06;
  localparam logic [4:0] SIDX_WAKE1    = 5'h07;
  localparam logic [4:0] SIDX_WAKE_LVL = 5'h08;
  localparam logic [4:0] SIDX_IO_OC    = 5'h14;
  localparam logic [4:0] SIDX_IO_OL    = 5'h15;
  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int         MODE_MSB        = 7;
  localparam int         MODE_LSB        = 6;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  localparam int         LOCK0_BIT       = 3;
  localparam int         LOCK1_BIT       = 0;
  localparam int         SPI_FAIL_BIT    = 1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [31:0][7:0] srb_bank_t;
  typedef struct packed {
    logic       we;
    logic [4:0] idx;
    logic [7:0] mask;
    logic [7:0] data;
  } srb_hw_upd_t;
  typedef struct packed {
    logic [7:0] wmask;
    logic [7:0] por;
    logic [7:0] rval;
    logic [7:0] rkeep;
    logic [7:0] hw;
    logic [7:0] lk0;
    logic [7:0] lk1;
  } srb_cattr_t;
  typedef struct packed {
    logic [7:0] valid;
    logic [7:0] clr;
    logic [7:0] por;
  } srb_sattr_t;

  // per-register bit types and reset images
  function automatic srb_cattr_t srb_ctrl_attr(input logic [4:0] idx);
    srb_cattr_t a;
    a = '0;
    a.rkeep = 8'hff;
    case (idx)
      IDX_MODE_SUPPLY: begin
        a.wmask = 8'hdf; a.hw = 8'hdc; a.rkeep = 8'h03;
      end
      IDX_HW_CTRL0: begin
        a.wmask = 8'h65; a.hw = 8'h20; a.lk0 = 8'h04; a.lk1 = 8'h40;
        a.rkeep = 8'h45;
      end
      IDX_WATCHDOG: begin
        a.wmask = 8'hf7; a.por = 8'h14; a.rval = 8'h04; a.rkeep = 8'hb0;
      end
      IDX_BUS_XCVR:   a.wmask = 8'h03;
      IDX_WAKE_INT:   a.wmask = 8'h44;
      IDX_WAKE_EXT:   a.wmask = 8'ha1;
      IDX_WAKE_PULL:  a.wmask = 8'hc3;
      IDX_BUS_FLASH:  a.wmask = 8'h10;
      IDX_CYC_TIMER:  a.wmask = 8'h7f;
      IDX_HW_CTRL1:   a.wmask = 8'hb8;
      IDX_HW_CTRL2:   a.wmask = 8'hfd;
      IDX_IO_PIN: begin
        a.wmask = 8'h07; a.lk0 = 8'h07;
      end
      IDX_PULSE_DUTY: a.wmask = 8'hff;
      IDX_PULSE_FREQ: a.wmask = 8'h03;
      IDX_HW_CTRL3:   a.wmask = 8'h07;
      IDX_SCRATCH_LO: a.wmask = 8'hff;
      IDX_SCRATCH_HI: a.wmask = 8'hff;
      default: ;
    endcase
    return a;
  endfunction : srb_ctrl_attr

  function automatic srb_sattr_t srb_stat_attr(input logic [4:0] idx);
    srb_sattr_t a;
    a = '0;
    case (idx)
      SIDX_SUPPLY1:  begin a.valid = 8'h63; a.clr = 8'h63; end
      SIDX_SUPPLY0:  begin a.valid = 8'h9d; a.clr = 8'h9d; a.por = 8'h80; end
      SIDX_THERMAL:  begin a.valid = 8'h0f; a.clr = 8'h0f; end
      SIDX_DEVICE:   begin a.valid = 8'hcf; a.clr = 8'hcf; end
      SIDX_BUS_FAIL: begin a.valid = 8'h07; a.clr = 8'h07; end
      SIDX_WAKE0:    begin a.valid = 8'h31; a.clr = 8'h31; end
      SIDX_WAKE1:    begin a.valid = 8'h10; a.clr = 8'h10; end
      SIDX_WAKE_LVL: a.valid = 8'hd1;
      SIDX_IO_OC:    begin a.valid = 8'h40; a.clr = 8'h40; end
      SIDX_IO_OL:    begin a.valid = 8'h40; a.clr = 8'h40; end
      default: ;
    endcase
    return a;
  endfunction : srb_stat_attr

  function automatic srb_bank_t srb_ctrl_por();
    srb_bank_t  b;
    srb_cattr_t a;
    for (int i = 0; i < 32; i++) begin
      a    = srb_ctrl_attr(5'(i));
      b[i] = a.por;
    end
    return b;
  endfunction : srb_ctrl_por

  function automatic srb_bank_t srb_stat_por();
    srb_bank_t  b;
    srb_sattr_t a;
    for (int i = 0; i < 32; i++) begin
      a    = srb_stat_attr(5'(i));
      b[i] = a.por;
    end
    return b;
  endfunction : srb_stat_por

  localparam srb_bank_t CTRL_POR = srb_ctrl_por();
  localparam srb_bank_t STAT_POR = srb_stat_por();
endpackage : srb_pkg
`default_nettype wire

// [verilog/srb_spi_bank.sv]
// Functional notes
// (RQ1) one access is one sixteen-bit word
// (RQ2) data byte sits in word bits 15..8
// (RQ3) access bit zero reads without modifying
// (RQ4) access bit one writes or clears
// (RQ5) read-only and reserved bits ignore writes
// (RQ6) plain bits store and return written value
// (RQ7) hardware-modifiable bits take host and device updates
// (RQ8) lockable bits refuse writes while any lock set
// (RQ9) level-0 lock survives soft reset until cleared
// (RQ10) level-1 lock holds until power-on reset
// (RQ11) soft reset spares locked configurations only
// (RQ12) power-on or reset command loads reset values
// (RQ13) restart entry loads restart values, keeps don't-cares
// (RQ14) reserved bits read zero; host writes zero
// (RQ15) control bits change only by host, except hardware-type
// (RQ16) one word addresses exactly one register
// (RQ17) writes take effect when chip select rises
// (RQ18) frames during restart mode are ignored
// (RQ19) every response starts with status summary byte
// (RQ20) wrong-length frame discarded, flags spi failure
`timescale 1ns/100ps
`default_nettype none
module srb_spi_bank #(
  parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary value
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_spi_clk,
  input  wire logic                i_chip_select_low_active_n,
  input  wire logic                i_mosi,
  output logic                     o_miso,
  output logic                     o_miso_oe,
  input  wire logic                i_soft_reset,
  input  wire logic                i_restart_mode,
  input  wire srb_pkg::srb_bank_t  i_stat_set,
  input  wire logic [7:0]          i_wake_level,
  input  wire srb_pkg::srb_hw_upd_t i_hw_upd,
  output srb_pkg::srb_bank_t       o_ctrl,
  output logic                     o_soft_reset
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]         cs_s;
    logic [2:0]         tgl_s;
    logic               tgl_seen;
    logic               restart_d;
    logic               sr_pend;
    logic               sr_pulse;
    srb_pkg::srb_bank_t ctrl;
    srb_pkg::srb_bank_t stat;
    srb_pkg::srb_bank_t snap_c;
    srb_pkg::srb_bank_t snap_s;
    logic [7:0]         snap_sum;
  } srb_core_t;

  // bit counter and read byte; cleared by chip select high
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] rd_byte;
  } srb_frame_t;

  // last frame as seen at the link; survives chip select high
  typedef struct packed {
    logic [15:0] rx;
    logic [4:0]  len;
    logic        tgl;
  } srb_hold_t;

  localparam srb_core_t CORE_RST = '{
    cs_s:   3'h7,
    ctrl:   srb_pkg::CTRL_POR,
    stat:   srb_pkg::STAT_POR,
    snap_c: srb_pkg::CTRL_POR,
    snap_s: srb_pkg::STAT_POR,
    default: '0
  };

  srb_core_t  core_ff, nxt_core;
  srb_frame_t frm_ff,  nxt_frm;
  srb_hold_t  hold_ff, nxt_hold;
  logic       frame_rst_n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] summary(input srb_pkg::srb_bank_t s);
    summary = {|s[srb_pkg::SIDX_IO_OL], |s[srb_pkg::SIDX_IO_OC],
               |s[srb_pkg::SIDX_SUPPLY1],
               |(s[srb_pkg::SIDX_WAKE0] | s[srb_pkg::SIDX_WAKE1]),
               |s[srb_pkg::SIDX_BUS_FAIL], |s[srb_pkg::SIDX_DEVICE],
               |s[srb_pkg::SIDX_THERMAL], |s[srb_pkg::SIDX_SUPPLY0]}; // RQ19
  endfunction : summary

  // whole-word decode: one address picks one byte
  function automatic logic [7:0] read_byte(input logic [6:0] a,
                                           input srb_pkg::srb_bank_t c,
                                           input srb_pkg::srb_bank_t s);
    read_byte = 8'h00;
    if (a == srb_pkg::ADR_FAMILY_ID)
      read_byte = FAMILY_ID;
    else if (a[6:5] == srb_pkg::REGION_CTRL)
      read_byte = c[a[4:0]];
    else if (a[6:5] == srb_pkg::REGION_STAT)
      read_byte = s[a[4:0]]; // RQ16
  endfunction : read_byte

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  assign frame_rst_n = i_reset_n & ~i_chip_select_low_active_n;

  always_comb begin
    nxt_frm = frm_ff;
    if (frm_ff.cnt != srb_pkg::CNT_MAX)
      nxt_frm.cnt = frm_ff.cnt + 5'h01;
    // address complete with this edge; the old contents go out
    if (frm_ff.cnt == srb_pkg::CNT_ADDR_LAST)
      nxt_frm.rd_byte = read_byte({i_mosi, hold_ff.rx[15:10]},
                                  core_ff.snap_c, core_ff.snap_s); // RQ3
    nxt_hold     = hold_ff;
    nxt_hold.rx  = {i_mosi, hold_ff.rx[15:1]}; // RQ1
    nxt_hold.len = nxt_frm.cnt;
    if (frm_ff.cnt == 5'h00)
      nxt_hold.tgl = ~hold_ff.tgl;
  end

  always_ff @(posedge i_spi_clk or negedge frame_rst_n) begin
    if (!frame_rst_n)
      frm_ff <= '0;
    else
      frm_ff <= nxt_frm;
  end

  always_ff @(posedge i_spi_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      hold_ff <= '0;
    else
      hold_ff <= nxt_hold;
  end

  // summary first, then the addressed byte, lsb first
  always_comb begin
    if (frm_ff.cnt < srb_pkg::CNT_DATA_FIRST)
      o_miso = core_ff.snap_sum[frm_ff.cnt[2:0]]; // RQ19
    else if (frm_ff.cnt < srb_pkg::FRAME_LEN)
      o_miso = frm_ff.rd_byte[frm_ff.cnt[2:0]]; // RQ2
    else
      o_miso = 1'b0;
  end

  assign o_miso_oe = ~i_chip_select_low_active_n;

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  always_comb begin
    srb_pkg::srb_cattr_t ca;
    srb_pkg::srb_sattr_t sa;
    logic [6:0]          a;
    logic [7:0]          d;
    logic [7:0]          m;
    logic [7:0]          keep;
    logic                lk0;
    logic                lk1;
    logic                fend;
    ca   = '0;
    sa   = '0;
    a    = hold_ff.rx[srb_pkg::ADR_MSB:0];
    d    = hold_ff.rx[srb_pkg::FRAME_BITS-1:srb_pkg::DATA_LSB]; // RQ2
    m    = '0;
    keep = '0;
    lk0  = core_ff.ctrl[srb_pkg::IDX_HW_CTRL1][srb_pkg::LOCK0_BIT];
    lk1  = core_ff.ctrl[srb_pkg::IDX_HW_CTRL2][srb_pkg::LOCK1_BIT];
    fend = core_ff.cs_s[1] & ~core_ff.cs_s[2];
    nxt_core           = core_ff;
    nxt_core.cs_s      = {core_ff.cs_s[1:0], i_chip_select_low_active_n};
    nxt_core.tgl_s     = {core_ff.tgl_s[1:0], hold_ff.tgl};
    nxt_core.restart_d = i_restart_mode;
    nxt_core.sr_pulse  = 1'b0;

    // commit at frame end only; a new toggle marks a frame with clocks
    if (fend && core_ff.tgl_s[2] != core_ff.tgl_seen) begin
      nxt_core.tgl_seen = core_ff.tgl_s[2];
      if (i_restart_mode) begin
        nxt_core.tgl_seen = core_ff.tgl_s[2]; // RQ18
      end else if (hold_ff.len != srb_pkg::FRAME_LEN) begin
        nxt_core.stat[srb_pkg::SIDX_DEVICE][srb_pkg::SPI_FAIL_BIT] = 1'b1; // RQ20
      end else if (hold_ff.rx[srb_pkg::ACCESS_BIT]) begin // RQ4
        if (a[6:5] == srb_pkg::REGION_CTRL) begin
          ca = srb_pkg::srb_ctrl_attr(a[4:0]);
          m  = ca.wmask & ~((lk0 | lk1) ? (ca.lk0 | ca.lk1) : 8'h00); // RQ5 RQ8
          nxt_core.ctrl[a[4:0]] = (core_ff.ctrl[a[4:0]] & ~m) | (d & m); // RQ6 RQ14
          if (lk1)
            nxt_core.ctrl[srb_pkg::IDX_HW_CTRL2][srb_pkg::LOCK1_BIT] = 1'b1; // RQ10
          if (a[4:0] == srb_pkg::IDX_MODE_SUPPLY &&
              d[srb_pkg::MODE_MSB:srb_pkg::MODE_LSB] == srb_pkg::MODE_SOFT_RESET)
            nxt_core.sr_pend = 1'b1; // RQ12
        end else if (a[6:5] == srb_pkg::REGION_STAT) begin
          sa = srb_pkg::srb_stat_attr(a[4:0]);
          nxt_core.stat[a[4:0]] = core_ff.stat[a[4:0]] & ~sa.clr; // RQ5
        end
      end
    end

    // device events after the clear: a set in the clearing cycle wins
    for (int i = 0; i < 32; i++) begin
      sa = srb_pkg::srb_stat_attr(5'(i));
      nxt_core.stat[i] = nxt_core.stat[i] | (i_stat_set[i] & sa.clr);
    end
    sa = srb_pkg::srb_stat_attr(srb_pkg::SIDX_WAKE_LVL);
    nxt_core.stat[srb_pkg::SIDX_WAKE_LVL] = i_wake_level & sa.valid; // RQ5

    // device logic may move only its own bit types
    if (i_hw_upd.we) begin
      ca = srb_pkg::srb_ctrl_attr(i_hw_upd.idx);
      m  = ca.hw & i_hw_upd.mask; // RQ7 RQ15
      nxt_core.ctrl[i_hw_upd.idx] =
        (nxt_core.ctrl[i_hw_upd.idx] & ~m) | (i_hw_upd.data & m);
    end

    // soft reset overrides host writes and hardware updates in its cycle; restart entry overrides it
    if (core_ff.sr_pend || i_soft_reset) begin
      nxt_core.sr_pend  = 1'b0;
      nxt_core.sr_pulse = 1'b1;
      for (int i = 0; i < 32; i++) begin
        ca   = srb_pkg::srb_ctrl_attr(5'(i));
        keep = (lk0 ? ca.lk0 : 8'h00) | (lk1 ? ca.lk1 : 8'h00); // RQ11
        nxt_core.ctrl[i] = (core_ff.ctrl[i] & keep) | (ca.por & ~keep); // RQ12
      end
      nxt_core.ctrl[srb_pkg::IDX_HW_CTRL1][srb_pkg::LOCK0_BIT] = lk0; // RQ9
      nxt_core.ctrl[srb_pkg::IDX_HW_CTRL2][srb_pkg::LOCK1_BIT] = lk1; // RQ10
    end

    // restart entry: don't-care bits keep their contents
    if (i_restart_mode && !core_ff.restart_d) begin
      nxt_core.sr_pend = 1'b0;
      for (int i = 0; i < 32; i++) begin
        ca = srb_pkg::srb_ctrl_attr(5'(i));
        nxt_core.ctrl[i] = (core_ff.ctrl[i] & ca.rkeep) | (ca.rval & ~ca.rkeep); // RQ13
      end
    end

    // frozen image while a frame may run, so the link sees stable data
    if (core_ff.cs_s[1]) begin
      nxt_core.snap_c   = core_ff.ctrl; // RQ17
      nxt_core.snap_s   = core_ff.stat;
      nxt_core.snap_sum = summary(core_ff.stat);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      core_ff <= CORE_RST; // RQ12
    else
      core_ff <= nxt_core;
  end

  assign o_ctrl       = core_ff.ctrl;
  assign o_soft_reset = core_ff.sr_pulse;
endmodule : srb_spi_bank
`default_nettype wire

// [test/srb_spi_bank_props.sv]
`timescale 1ns/100ps
`default_nettype none
module srb_spi_bank_props (
  input wire logic                 i_clk,
  input wire logic                 i_reset_n,
  input wire logic                 i_spi_clk,
  input wire logic                 i_chip_select_low_active_n,
  input wire logic                 i_mosi,
  input wire logic                 o_miso,
  input wire logic                 o_miso_oe,
  input wire logic                 i_soft_reset,
  input wire logic                 i_restart_mode,
  input wire srb_pkg::srb_bank_t   i_stat_set,
  input wire logic [7:0]           i_wake_level,
  input wire srb_pkg::srb_hw_upd_t i_hw_upd,
  input wire srb_pkg::srb_bank_t   o_ctrl,
  input wire logic                 o_soft_reset
);
  // ----------------------------------------------------------------
  // core-domain checks; link effects are judged where they land
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic quiet;
  logic lk0;
  logic lk1;
  assign quiet = !i_hw_upd.we && !i_soft_reset && !i_restart_mode;
  assign lk0   = o_ctrl[5'h0e][3];
  assign lk1   = o_ctrl[5'h0f][0];

  property p_oe_cs;
    o_miso_oe == !i_chip_select_low_active_n;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("miso enable not tied to select");
  property p_sr;
    i_soft_reset |=> o_soft_reset && o_ctrl[5'h03] == 8'h14 && o_ctrl[5'h1e] == 8'h00;
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset image wrong");
  // commit waits for select high, so nothing moves mid-frame
  property p_frame;
    (!i_chip_select_low_active_n && quiet) |=> $stable(o_ctrl);
  endproperty
  a_frame: assert property (p_frame) else $error("control moved inside frame");
  property p_restart;
    (i_restart_mode && $past(i_restart_mode, 2) && !i_hw_upd.we && !i_soft_reset)
      |=> $stable(o_ctrl);
  endproperty
  a_restart: assert property (p_restart) else $error("control moved in restart");
  property p_lock1;
    lk1 |=> lk1;
  endproperty
  a_lock1: assert property (p_lock1) else $error("level one lock dropped");
  property p_lock0_sr;
    (lk0 && i_soft_reset) |=> lk0 && $stable(o_ctrl[5'h17]) && $stable(o_ctrl[5'h02][2]);
  endproperty
  a_lock0_sr: assert property (p_lock0_sr) else $error("locked config lost");
  property p_sr_free;
    (!lk0 && !lk1 && i_soft_reset) |=> o_ctrl[5'h17] == 8'h00 && o_ctrl[5'h02] == 8'h00;
  endproperty
  a_sr_free: assert property (p_sr_free) else $error("unlocked config kept");
  property p_resv;
    (o_ctrl[5'h02] & 8'h9a) == 8'h00 && o_ctrl[5'h04][7:2] == 6'h00 && !o_ctrl[5'h01][5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_hw;
    (i_hw_upd.we && i_hw_upd.idx == 5'h01 && !i_soft_reset && !i_restart_mode) |=>
      ((o_ctrl[5'h01] ^ $past(i_hw_upd.data)) & $past(i_hw_upd.mask) & 8'hdc) == 8'h00;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware update not applied");
endmodule : srb_spi_bank_props
bind srb_spi_bank srb_spi_bank_props srb_spi_bank_props_inst (
  .i_clk, .i_reset_n, .i_spi_clk, .i_chip_select_low_active_n, .i_mosi, .o_miso,
  .o_miso_oe, .i_soft_reset, .i_restart_mode, .i_stat_set, .i_wake_level, .i_hw_upd,
  .o_ctrl, .o_soft_reset
);
`default_nettype wire

// [test/srb_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module srb_host_model (
  output logic      o_spi_clk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // ----------------------------------------------------------------
  // frame master: link clock runs only inside frames
  // ----------------------------------------------------------------
  initial begin
    o_spi_clk = 1'b0;
    o_cs_n    = 1'b1;
    o_mosi    = 1'b0;
  end
  // n other than 16 gives a deliberately malformed frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    #7 o_cs_n = 1'b0;
    #32;
    for (int k = 0; k < n; k++) begin
      o_mosi = w[k];
      #32 r[k] = i_miso;
      o_spi_clk = 1'b1;
      #32 o_spi_clk = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    // released line has no pull, so show a changed level
    o_mosi = ~o_mosi;
    #305;  // gap keeps 16-bit frames on a fixed core-clock phase
  endtask : xfer
endmodule : srb_host_model
`default_nettype wire

// [test/tb_srb_spi_bank.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_srb_spi_bank;
  // ----------------------------------------------------------------
  // stimulus and harness
  // ----------------------------------------------------------------
  localparam logic [7:0] FAM = 8'h3c;  // arbitrary value
  logic                 i_clk          = 1'b0;
  logic                 i_reset_n      = 1'b0;
  logic                 i_soft_reset   = 1'b0;
  logic                 i_restart_mode = 1'b0;
  logic [7:0]           i_wake_level   = 8'hff;
  srb_pkg::srb_bank_t   i_stat_set     = '0;
  srb_pkg::srb_hw_upd_t i_hw_upd       = '0;
  srb_pkg::srb_bank_t   o_ctrl;
  logic                 spi_clk, cs_n, mosi, o_miso, o_miso_oe, o_soft_reset;
  int                   n_mismatch     = 0;
  int                   comparisons    = 0;
  always #10 i_clk = ~i_clk;
  srb_spi_bank #(.FAMILY_ID(FAM)) srb_spi_bank_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_clk(spi_clk),
    .i_chip_select_low_active_n(cs_n), .i_mosi(mosi), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_soft_reset(i_soft_reset), .i_restart_mode(i_restart_mode),
    .i_stat_set(i_stat_set), .i_wake_level(i_wake_level), .i_hw_upd(i_hw_upd),
    .o_ctrl(o_ctrl), .o_soft_reset(o_soft_reset));
  srb_host_model srb_host_model_inst (
    .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(o_miso));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic spi(input logic [6:0] a, input logic w, input logic [7:0] d,
                     output logic [15:0] r);
    srb_host_model_inst.xfer({d, w, a}, 16, r);
  endtask : spi
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    spi(a, 1'b0, 8'h00, r);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    spi(a, 1'b1, d, r);
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic por();
    @(negedge i_clk);
    i_reset_n = 1'b0;
    cyc(5);
    i_reset_n = 1'b1;
    cyc(5);
  endtask : por
  task automatic sr();
    cyc(1);
    i_soft_reset = 1'b1;
    cyc(1);
    i_soft_reset = 1'b0;
    cmp({7'h00, o_soft_reset}, 8'h01);
    cmp(o_ctrl[3], 8'h14);
    cyc(1);
    cmp({7'h00, o_soft_reset}, 8'h00);
  endtask : sr
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_basic();
    logic [15:0] r;
    rd(7'h41, r);
    cmp(r[15:8], 8'h80);
    cmp(r[7:0], 8'h01);
    spi(7'h1e, 1'b1, 8'h55, r);
    cmp(r[15:8], 8'h00);
    cmp(o_ctrl[30], 8'h55);
    wr(7'h1f, 8'haa);
    spi(7'h1e, 1'b0, 8'hff, r);
    cmp(r[15:8], 8'h55);
    cmp(o_ctrl[30], 8'h55);
    wr(7'h04, 8'hff);
    rd(7'h04, r);
    cmp(r[15:8], 8'h03);
    wr(7'h7e, 8'h00);
    rd(7'h7e, r);
    cmp(r[15:8], FAM);
    rd(7'h48, r);
    cmp(r[15:8], 8'hd1);
    cyc(1);
    i_wake_level = 8'h3e;
    rd(7'h48, r);
    cmp(r[15:8], 8'h10);
    $display("test basic access done");
  endtask : t_basic
  task automatic t_status();
    logic [15:0] r;
    cyc(1);
    i_stat_set[2] = 8'h0f;
    cyc(1);
    i_stat_set[2] = 8'h00;
    rd(7'h42, r);
    cmp(r[15:8], 8'h0f);
    cmp(r[7:0], 8'h03);
    wr(7'h42, 8'h00);
    wr(7'h41, 8'h00);
    srb_host_model_inst.xfer({8'h11, 1'b1, 7'h1e}, 15, r);
    cmp(o_ctrl[30], 8'h55);
    rd(7'h43, r);
    cmp(r[15:8], 8'h02);
    cmp(r[7:0], 8'h04);
    $display("test status done");
  endtask : t_status
  task automatic t_restart();
    wr(7'h03, 8'hff);
    wr(7'h01, 8'h1b);
    cmp(o_ctrl[3], 8'hf7);
    cyc(1);
    i_restart_mode = 1'b1;
    cyc(2);
    cmp(o_ctrl[3], 8'hb4);
    cmp(o_ctrl[1], 8'h03);
    wr(7'h1f, 8'h77);
    cmp(o_ctrl[31], 8'haa);
    i_restart_mode = 1'b0;
    cyc(1);
    i_hw_upd = '{we: 1'b1, idx: 5'h01, mask: 8'hff, data: 8'h38};
    cyc(1);
    i_hw_upd = '{we: 1'b1, idx: 5'h1e, mask: 8'hff, data: 8'h00};
    cyc(1);
    i_hw_upd.we = 1'b0;
    cyc(1);
    cmp(o_ctrl[1], 8'h1b);
    cmp(o_ctrl[30], 8'h55);
    $display("test restart and hardware update done");
  endtask : t_restart
  task automatic t_lock();
    wr(7'h02, 8'h04);
    wr(7'h17, 8'h05);
    wr(7'h0e, 8'h08);
    wr(7'h17, 8'h02);
    cmp(o_ctrl[23], 8'h05);
    sr();
    cmp(o_ctrl[2], 8'h04);
    cmp(o_ctrl[14], 8'h08);
    cmp(o_ctrl[30], 8'h00);
    wr(7'h0e, 8'h00);
    wr(7'h17, 8'h02);
    cmp(o_ctrl[23], 8'h02);
    sr();
    cmp(o_ctrl[23], 8'h00);
    wr(7'h02, 8'h40);
    wr(7'h0f, 8'h01);
    wr(7'h02, 8'h00);
    cmp(o_ctrl[2], 8'h40);
    sr();
    cmp(o_ctrl[2], 8'h40);
    wr(7'h03, 8'h00);
    wr(7'h01, 8'hc0);
    cmp(o_ctrl[3], 8'h14);
    por();
    cmp(o_ctrl[15], 8'h00);
    cmp(o_ctrl[2], 8'h00);
    $display("test locks done");
  endtask : t_lock
  initial begin
    por();
    t_basic();
    t_status();
    t_restart();
    t_lock();
    results();
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    results();
  end
endmodule : tb_srb_spi_bank
`default_nettype wire
